// >>> rtl/sac_pkg.sv
// Shared types and constants for the serial successive-approximation converter control
package sac_pkg;
  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int RES_W       = 12;     // Result word width
  localparam int CTRL_W      = 8;      // Control byte width
  localparam int FIFO_DEPTH  = 8;      // Result queue depth
  localparam int SYNC_W      = 6;      // Number of synchronised pins

  // ****************************************************************
  // Control byte positions and sequence counts
  // ****************************************************************
  localparam logic [3:0] BIT_TRACK = 4'h5;   // Bits in before tracking starts
  localparam logic [3:0] BIT_LAST  = 4'h8;   // Bits in a full control byte
  localparam logic [3:0] BIT_MSB   = 4'hb;   // Index of result MSB
  localparam logic [RES_W-1:0] SAR_START = 12'h800;  // First trial code
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h20;    // Select reads idle high

  // ****************************************************************
  // Power and clock modes
  // ****************************************************************
  localparam logic [1:0] PM_FULL_PD = 2'h0;  // Full power-down
  localparam logic [1:0] PM_FAST_PD = 2'h1;  // Fast power-down
  localparam logic [1:0] PM_INT_CLK = 2'h2;  // Internal clock conversion
  localparam logic [1:0] PM_EXT_CLK = 2'h3;  // External clock conversion

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;          // System clock period
  localparam int INT_BIT_NS    = 400;        // Internal clock time per decision
  localparam int INT_BIT_CYC   = (INT_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INT_BIT_LAST = 8'(INT_BIT_CYC - 1);  // Tick terminal count

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       start;        // Start bit
    logic       channel_select_hi;
    logic       channel_select_mid;
    logic       channel_select_lo;
    logic       polarity_select;      // 1 unipolar, 0 bipolar
    logic       input_config_select;  // 1 single-ended, 0 differential
    logic       power_mode_hi;
    logic       power_mode_lo;
  } sac_ctrl_t;

  typedef struct packed {
    logic [2:0] posSel;       // Channel on the positive comparator input
    logic [2:0] negSel;       // Channel on the negative input
    logic       negGnd;       // Negative input tied to ground
    logic       unipolar;     // Unipolar coding
  } sac_mux_t;
endpackage

// >>> rtl/sac_serial_adc.sv
// Serial control, sequencing and result queue of the eight-input 12-bit converter
`timescale 1ns/1ps

// ****************************************************************
// Result queue
// ****************************************************************
module sac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Storage
  logic [AW:0]      wrPtr;           // Write pointer with wrap bit
  logic [AW:0]      rdPtr;           // Read pointer with wrap bit

  // Full when pointers differ only in the wrap bit
  assign inReady  = (wrPtr != {~rdPtr[AW], rdPtr[AW-1:0]});
  assign outValid = (wrPtr != rdPtr);
  assign outData  = mem[rdPtr[AW-1:0]];

  // Write side
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wrPtr <= '0;
    end else if (clkEn && inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
      wrPtr              <= wrPtr + 1'b1;
    end
  end

  // Read side
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdPtr <= '0;
    end else if (clkEn && outValid && outReady) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule

// Behaviour
// - Data output changes only on clock falls
// - Data output floats while select high
// - Data input sampled on clock rises
// - Input bits ignored while select high
// - Internal mode: strobe low busy, high done
// - External mode: strobe one period before MSB
// - External mode: strobe floats while select high
// - External mode: serial clock steps decisions
// - Acquisition ends on fall after last bit
// - Track starts on fall after bit five
// - Hold on fall after bit eight, convert
// - Single-ended: channel positive, ground negative
// - Differential: fixed adjacent channel pairs
// - Shutdown pin three-level, low shuts down
// - Capacitor back to positive after conversion
// - Result is twelve-bit successive approximation
// - External cycle spans fifteen serial clocks
// - Leading zeros skipped; first one starts
// - Control byte field decode
// - Power-mode bits select power or clock
// - Channel index from select bits order
module sac_serial_adc
  import sac_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  input  wire logic             chipSelectN,
  input  wire logic             serialClk,
  input  wire logic             serialDataIn,
  input  wire logic             comparatorHigh,
  input  wire logic             shutdownPinLow,
  input  wire logic             shutdownPinHigh,
  output logic                  serialDataOut,
  output logic                  serialDataOutEn,
  output logic                  serial_strobe,
  output logic                  serialStrobeEn,
  output logic                  sampling_capacitor,
  output sac_mux_t              muxCfg,
  output logic      [RES_W-1:0] dacCode,
  output logic                  shutdownActive,
  output logic                  fullPowerDown,
  output logic                  fastPowerDown,
  output logic                  refCompInternal,
  output logic                  convBusy
);
  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [SYNC_W-1:0] syncA;          // First stage, read only by syncB
  logic [SYNC_W-1:0] syncB;          // Second stage
  logic              sclkPrev;       // Previous synchronised serial clock

  // Two flip-flops on every outside pin
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      syncA <= SYNC_RST;
      syncB <= SYNC_RST;
    end else if (clkEn) begin
      syncA <= {chipSelectN, serialClk, serialDataIn, comparatorHigh,
                shutdownPinLow, shutdownPinHigh};
      syncB <= syncA;
    end
  end

  // Clock history for edge finding
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sclkPrev <= 1'b0;
    end else if (clkEn) begin
      sclkPrev <= syncB[4];
    end
  end

  logic csLow;                       // Select asserted
  logic dinS;                        // Synchronised data input
  logic compS;                       // Synchronised comparator decision
  logic shdnLowS;                    // Shutdown pin pulled low
  logic sclkRise;                    // Serial clock rising, select low
  logic sclkFall;                    // Serial clock falling, select low
  assign csLow    = ~syncB[5];
  assign dinS     = syncB[3];
  assign compS    = syncB[2];
  assign shdnLowS = syncB[1];
  assign sclkRise = csLow & syncB[4] & ~sclkPrev;
  assign sclkFall = csLow & ~syncB[4] & sclkPrev;

  // ****************************************************************
  // Control byte receiver
  // ****************************************************************
  logic            rxStarted;        // Start bit seen
  logic [3:0]      rxCount;          // Bits received including start
  logic [7:0]      rxShift;          // Received bits
  logic            trackEvt;         // Fall after fifth bit
  logic            byteDone;         // Fall after eighth bit
  sac_ctrl_t       ctrl;             // Decoded view of the byte

  assign trackEvt = sclkFall & (rxCount == BIT_TRACK);
  assign byteDone = sclkFall & (rxCount == BIT_LAST);
  assign ctrl     = sac_ctrl_t'(rxShift);

  // Hunt for the start bit, then shift the byte in
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rxStarted <= 1'b0;
      rxCount   <= 4'h0;
      rxShift   <= 8'h00;
    end else if (clkEn) begin
      if (!csLow) begin
        // Partial byte dropped on deselect
        rxStarted <= 1'b0;
        rxCount   <= 4'h0;
      end else if (byteDone) begin
        // Hunt again at once, so the next byte may overlap the conversion
        rxStarted <= 1'b0;
        rxCount   <= 4'h0;
      end else if (sclkRise) begin
        if (!rxStarted) begin
          // Zeros before the start bit have no effect
          if (dinS) begin
            rxStarted <= 1'b1;
            rxCount   <= 4'h1;
            rxShift   <= 8'h01;
          end
        end else if (rxCount != BIT_LAST) begin
          rxCount <= rxCount + 4'h1;
          rxShift <= {rxShift[6:0], dinS};
        end
      end
    end
  end

  // ****************************************************************
  // Configuration latch and input multiplexer
  // ****************************************************************
  logic [1:0] pwrMode;               // Latched power/clock mode
  logic       extMode;               // External clock mode latched
  assign extMode = (pwrMode == PM_EXT_CLK);

  // Latch mode and mux routing at the end of each byte
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pwrMode <= PM_INT_CLK;
      muxCfg  <= '0;
    end else if (clkEn && byteDone) begin
      pwrMode         <= {ctrl.power_mode_hi, ctrl.power_mode_lo};
      muxCfg.unipolar <= ctrl.polarity_select;
      if (ctrl.input_config_select) begin
        // Single-ended: index is mid, lo, hi bits
        muxCfg.posSel <= {ctrl.channel_select_mid, ctrl.channel_select_lo,
                          ctrl.channel_select_hi};
        muxCfg.negSel <= 3'h0;
        muxCfg.negGnd <= 1'b1;
      end else begin
        // Differential: pair from mid, lo; hi swaps polarity
        muxCfg.posSel <= {ctrl.channel_select_mid, ctrl.channel_select_lo,
                          ctrl.channel_select_hi};
        muxCfg.negSel <= {ctrl.channel_select_mid, ctrl.channel_select_lo,
                          ~ctrl.channel_select_hi};
        muxCfg.negGnd <= 1'b0;
      end
    end
  end

  // Power-down flags, cleared by any converting byte
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fullPowerDown <= 1'b0;
      fastPowerDown <= 1'b0;
    end else if (clkEn && byteDone) begin
      fullPowerDown <= ({ctrl.power_mode_hi, ctrl.power_mode_lo} == PM_FULL_PD);
      fastPowerDown <= ({ctrl.power_mode_hi, ctrl.power_mode_lo} == PM_FAST_PD);
    end
  end

  // Three-level shutdown: low stops, high picks internal compensation
  assign shutdownActive  = shdnLowS;
  assign refCompInternal = syncB[0] & ~shdnLowS;

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,             // Waiting for a converting byte
    ST_XSTRB = 5'b00010,             // External: strobe period
    ST_XCONV = 5'b00100,             // External: decisions on falls
    ST_ICONV = 5'b01000,             // Internal: timed decisions
    ST_IPUSH = 5'b10000              // Internal: queue the result
  } sac_state_t;

  sac_state_t       state;           // Sequencer state
  logic [3:0]       bitIdx;          // Bit being decided
  logic [7:0]       tick;            // Internal decision timer
  logic             decide;          // Take a decision this cycle
  logic             startConv;       // Converting byte accepted
  logic             qValid;          // Result offered to queue
  logic             qReady;          // Queue accepts the result

  assign startConv = byteDone & ~shdnLowS & ctrl.power_mode_hi;
  assign decide    = ((state == ST_XSTRB) | (state == ST_XCONV)) ? sclkFall
                   : ((state == ST_ICONV) & (tick == INT_BIT_LAST));
  assign qValid    = (state == ST_IPUSH);
  assign convBusy  = (state != ST_IDLE);

  // State transitions
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else if (clkEn) begin
      unique case (state)
        ST_IDLE: begin
          if (startConv) begin
            state <= ctrl.power_mode_lo ? ST_XSTRB : ST_ICONV;
          end
        end
        ST_XSTRB: begin
          // Strobe period ends with the MSB decision
          if (!csLow) begin
            state <= ST_IDLE;
          end else if (decide) begin
            state <= ST_XCONV;
          end
        end
        ST_XCONV: begin
          if (!csLow || (decide && bitIdx == 4'h0)) begin
            state <= ST_IDLE;
          end
        end
        ST_ICONV: begin
          if (decide && bitIdx == 4'h0) begin
            state <= ST_IPUSH;
          end
        end
        ST_IPUSH: begin
          // Stalls here while the queue is full
          if (qReady) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Internal decision timer
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tick <= 8'h00;
    end else if (clkEn) begin
      tick <= (state != ST_ICONV || tick == INT_BIT_LAST) ? 8'h00 : tick + 8'h01;
    end
  end

  // Successive approximation register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dacCode <= 12'h000;
      bitIdx  <= 4'h0;
    end else if (clkEn) begin
      if (state == ST_IDLE && startConv) begin
        dacCode <= SAR_START;
        bitIdx  <= BIT_MSB;
      end else if (decide) begin
        // Keep or drop the trial bit, try the next one
        dacCode[bitIdx] <= compS;
        if (bitIdx != 4'h0) begin
          dacCode[bitIdx - 4'h1] <= 1'b1;
          bitIdx                 <= bitIdx - 4'h1;
        end
      end
    end
  end

  // Sampling capacitor: track after bit five, hold after bit eight
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sampling_capacitor <= 1'b1;
    end else if (clkEn) begin
      if (byteDone && state == ST_IDLE && startConv) begin
        // Hold only when a conversion really starts from the sample
        sampling_capacitor <= 1'b0;
      end else if (trackEvt && state == ST_IDLE) begin
        // An overlapping byte must not disturb a held sample
        sampling_capacitor <= 1'b1;
      end else if (decide && bitIdx == 4'h0) begin
        sampling_capacitor <= 1'b1;
      end
    end
  end

  // Strobe: external pulse or internal busy/done
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serial_strobe <= 1'b1;
    end else if (clkEn) begin
      if (state == ST_IDLE && startConv) begin
        serial_strobe <= ctrl.power_mode_lo;
      end else if (state == ST_XSTRB && decide) begin
        serial_strobe <= 1'b0;
      end else if (state == ST_IPUSH && qReady) begin
        serial_strobe <= 1'b1;
      end
    end
  end

  assign serialStrobeEn  = extMode ? csLow : 1'b1;
  assign serialDataOutEn = csLow;

  // ****************************************************************
  // Result queue and output shifter
  // ****************************************************************
  logic [RES_W-1:0] qData;           // Word at queue head
  logic             qOutValid;       // Queue holds a word
  logic             qOutReady;       // Shifter takes a word
  logic [RES_W-1:0] outShift;        // Bits still to send
  logic [3:0]       outLeft;         // Count of bits still to send

  assign qOutReady = (outLeft == 4'h0) & ~convBusy;

  sac_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .inData   (dacCode),
    .inValid  (qValid),
    .inReady  (qReady),
    .outData  (qData),
    .outValid (qOutValid),
    .outReady (qOutReady)
  );

  // Data output moves only on serial clock falls
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      serialDataOut <= 1'b0;
      outShift      <= 12'h000;
      outLeft       <= 4'h0;
    end else if (clkEn) begin
      if (qOutValid && qOutReady) begin
        outShift <= qData;
        outLeft  <= BIT_MSB + 4'h1;
      end else if (decide && (state == ST_XSTRB || state == ST_XCONV)) begin
        serialDataOut <= compS;
      end else if (sclkFall) begin
        // Queued word leaves MSB first, zeros once empty
        serialDataOut <= (outLeft != 4'h0) & outShift[RES_W-1];
        outShift      <= {outShift[RES_W-2:0], 1'b0};
        if (outLeft != 4'h0) begin
          outLeft <= outLeft - 4'h1;
        end
      end
    end
  end
endmodule

// >>> tb/sac_serial_adc_asserts.sv
// Port-level concurrent checks for the serial converter control block
`timescale 1ns/1ps
module sac_serial_adc_asserts
  import sac_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             chipSelectN,
  input wire logic             serialClk,
  input wire logic             shutdownPinLow,
  input wire logic             shutdownPinHigh,
  input wire logic             serialDataOut,
  input wire logic             serialDataOutEn,
  input wire logic             serial_strobe,
  input wire logic             serialStrobeEn,
  input wire logic             sampling_capacitor,
  input wire logic [RES_W-1:0] dacCode,
  input wire logic             shutdownActive,
  input wire logic             refCompInternal,
  input wire logic             convBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic       clkQ;       // Serial clock one cycle back
  logic [3:0] sinceFall;  // Cycles since the last serial clock fall, saturating

  // ****************************************************************
  // Serial clock fall tracker
  // ****************************************************************
  // Restarts at each raw fall; parked at the top while in reset
  always_ff @(posedge sys_clk) begin
    clkQ <= serialClk;
    if (!nrst) begin
      sinceFall <= 4'hf;
    end else if (clkQ && !serialClk) begin
      sinceFall <= 4'h0;
    end else if (sinceFall != 4'hf) begin
      sinceFall <= sinceFall + 4'h1;
    end
  end

  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  sequence selIdle;
    chipSelectN[*3];
  endsequence
  sequence pinLow;
    shutdownPinLow[*4];
  endsequence
  sequence pinUp;
    (!shutdownPinLow)[*4];
  endsequence

  dout_float_a: assert property (selIdle |-> !serialDataOutEn)
    else $error("data output driven while deselected");
  strobe_float_a: assert property ($fell(serialStrobeEn) |->
    $past(chipSelectN, 2) || $past(chipSelectN, 3)) else $error("strobe released in frame");
  dout_edge_a: assert property (serialDataOutEn && $changed(serialDataOut) |->
    sinceFall inside {[4'h1:4'h7]}) else $error("data output moved off a clock fall");
  hold_edge_a: assert property ($fell(sampling_capacitor) |->
    sinceFall inside {[4'h1:4'h7]}) else $error("hold not on a clock fall");
  hold_busy_a: assert property ($fell(sampling_capacitor) |-> ##[0:2] convBusy)
    else $error("hold without conversion start");
  dac_start_a: assert property ($fell(sampling_capacitor) |->
    ##[0:2] (dacCode == SAR_START)) else $error("first trial code wrong");
  strobe_busy_a: assert property ($fell(serial_strobe) |-> convBusy)
    else $error("strobe fell while idle");
  shutdown_pin_on_a: assert property (pinLow |-> shutdownActive)
    else $error("low pin did not shut down");
  shutdown_pin_off_a: assert property (pinUp |-> !shutdownActive)
    else $error("shutdown without low pin");
  ref_int_a: assert property ((shutdownPinHigh && !shutdownPinLow)[*4] |->
    refCompInternal) else $error("high pin did not pick internal compensation");
endmodule

bind sac_serial_adc sac_serial_adc_asserts chk (.sys_clk, .nrst, .chipSelectN, .serialClk,
  .shutdownPinLow, .shutdownPinHigh, .serialDataOut, .serialDataOutEn, .serial_strobe,
  .serialStrobeEn, .sampling_capacitor, .dacCode, .shutdownActive, .refCompInternal,
  .convBusy);

// >>> tb/sac_host_model.sv
// Host serial master model driving the converter's link pins
`timescale 1ns/1ps
module sac_host_model (
  input  wire logic sys_clk,
  input  wire logic serialDataOut,
  input  wire logic serial_strobe,
  input  wire logic sampling_capacitor,
  output logic      chipSelectN,
  output logic      serialClk,
  output logic      serialDataIn
);
  localparam int HALF = 8;  // Half of the 80 ns link period in system cycles
  logic [31:0] rxData;      // Data output seen at each rise
  logic [31:0] rxStb;       // Strobe seen at each rise
  logic [31:0] rxCap;       // Capacitor state seen at each rise

  // Idle: deselected, clock parked low
  initial begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    serialDataIn = 1'b0;
  end

  // Change select, then leave a setup gap
  task automatic select(input logic lvl);
    @(negedge sys_clk) chipSelectN <= lvl;
    repeat (2 * HALF) @(negedge sys_clk);
  endtask

  // Clock n bits out MSB first at even duty, sampling at each rise
  task automatic shift(input logic [31:0] tx, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serialDataIn <= tx[i];
      repeat (HALF) @(negedge sys_clk);
      serialClk <= 1'b1;
      rxData = {rxData[30:0], serialDataOut};
      rxStb = {rxStb[30:0], serial_strobe};
      rxCap = {rxCap[30:0], sampling_capacitor};
      repeat (HALF) @(negedge sys_clk);
      serialClk <= 1'b0;
    end
    // Hold time over: line no longer shows the last bit
    @(negedge sys_clk) serialDataIn <= ~serialDataIn;
    @(negedge sys_clk);
  endtask
endmodule

// >>> tb/sac_serial_adc_test.sv
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
module sac_serial_adc_test;
  import sac_pkg::*;
  logic             sys_clk, nrst, clkEn, chipSelectN, serialClk, serialDataIn;
  logic             comparatorHigh, shutdownPinLow, shutdownPinHigh, serialDataOut;
  logic             serialDataOutEn, serial_strobe, serialStrobeEn, sampling_capacitor;
  logic             shutdownActive, fullPowerDown, fastPowerDown, refCompInternal, convBusy;
  sac_mux_t         muxCfg;     // Channel routing
  logic [RES_W-1:0] dacCode;    // Trial code
  logic [RES_W-1:0] anaCode;    // Input level, half a step above this code
  int               nMismatch = 0;
  int               checks = 0;

  sac_serial_adc dut (.sys_clk, .nrst, .clkEn, .chipSelectN, .serialClk, .serialDataIn,
    .comparatorHigh, .shutdownPinLow, .shutdownPinHigh, .serialDataOut, .serialDataOutEn,
    .serial_strobe, .serialStrobeEn, .sampling_capacitor, .muxCfg, .dacCode,
    .shutdownActive, .fullPowerDown, .fastPowerDown, .refCompInternal, .convBusy);
  sac_host_model host (.sys_clk, .serialDataOut, .serial_strobe, .sampling_capacitor,
    .chipSelectN, .serialClk, .serialDataIn);

  // Comparator: the half step keeps the expected result exact
  assign comparatorHigh = {anaCode, 1'b1} > {dacCode, 1'b0};

  // ****************************************************************
  // Clock, compare and verdict
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Abandoned byte, clocks while deselected, then external conversions 15 clocks apart
  task automatic testExt();
    anaCode = 12'ha5c;
    host.select(1'b0);
    host.shift(32'h5, 3);
    host.select(1'b1);
    host.shift(32'hf, 4);
    cmp("doutEnIdle", 32'h0, serialDataOutEn);
    host.select(1'b0);
    host.shift(32'h1be037c0, 32);
    cmp("extData", 32'ha5c, host.rxData[19:8]);
    cmp("extStrobe", 32'h2, host.rxStb[20:19]);
    cmp("extCycle", 32'h1, host.rxStb[8:5]);
    cmp("extCap", 32'h2001, host.rxCap[21:8]);
    cmp("extMux", 32'hf, {muxCfg.posSel, muxCfg.negGnd, muxCfg.unipolar});
    host.select(1'b1);
    cmp("extFloat", 32'h0, {serialDataOutEn, serialStrobeEn});
    $display("testExt done");
  endtask

  // Internal-clock conversions, each read out after done
  task automatic testInt();
    logic [11:0] code [2];
    code[0] = 12'h3c7;
    code[1] = 12'h0f1;
    host.select(1'b0);
    for (int k = 0; k < 2; k++) begin
      anaCode = code[k];
      host.shift(32'he2, 8);
      repeat (8) @(negedge sys_clk);
      cmp("intBusy", 32'h0, serial_strobe);
      if (k == 1) begin
        // Frozen longer than a conversion: still busy afterwards
        clkEn <= 1'b0;
        repeat (1000) @(negedge sys_clk);
        cmp("frzBusy", 32'h0, serial_strobe);
        clkEn <= 1'b1;
      end
      for (int i = 0; i < 2000 && serial_strobe !== 1'b1; i++) begin
        @(negedge sys_clk);
      end
      cmp("intDone", 32'h1, serial_strobe);
      cmp("intMux", 32'hb0, muxCfg);
      host.shift(32'h0, 13);
      cmp("intData", code[k], host.rxData[11:0]);
    end
    host.select(1'b1);
    $display("testInt done");
  endtask

  // Both power-down codes set their flags and start no conversion
  task automatic testPower();
    for (int m = 0; m < 2; m++) begin
      host.select(1'b0);
      host.shift({30'h2f, m[1:0]}, 8);
      repeat (8) @(negedge sys_clk);
      cmp("pdFlags", (m == 0) ? 32'h2 : 32'h1, {fullPowerDown, fastPowerDown});
      cmp("pdIdle", 32'h0, convBusy);
      host.select(1'b1);
    end
    $display("testPower done");
  endtask

  // Three pin levels, then a byte refused while shut down
  task automatic testShdn();
    logic [1:0] lvl [3];
    lvl = '{2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 3; i++) begin
      {shutdownPinLow, shutdownPinHigh} <= lvl[i];
      repeat (8) @(negedge sys_clk);
      cmp("shdnSense", {lvl[i][1], lvl[i] == 2'h1}, {shutdownActive, refCompInternal});
    end
    shutdownPinLow <= 1'b1;
    host.select(1'b0);
    host.shift(32'he2, 8);
    repeat (100) @(negedge sys_clk);
    cmp("shdnNoConv", 32'h1, {convBusy, serial_strobe});
    host.select(1'b1);
    shutdownPinLow <= 1'b0;
    $display("testShdn done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    shutdownPinLow = 1'b0;
    shutdownPinHigh = 1'b1;
    anaCode = 12'h0;
    repeat (16) @(negedge sys_clk);
    nrst <= 1'b1;
    testExt();
    testInt();
    testPower();
    testShdn();
    giveVerdict();
  end

  // Run needs about 5000 cycles; eight times that means a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    nMismatch++;
    giveVerdict();
  end
endmodule
